// file: cssu_clock_select_startup.sv
// clock source select, start-up sequencer and clock domain gating
// Behaviour
// - fuse code picks crystal, low-freq crystal, external RC, internal RC or external clock
// - fuse bit one is unprogrammed, zero is programmed
// - wake from power-down or power-save waits a source-cycle start-up count
// - start from reset adds a delay counted on the watchdog oscillator
// - reset delay is 4096 or 65536 watchdog oscillator cycles
// - factory fuses are source 0001 and start-up 10
// - crystal range codes 101, 110, 111 apply unless full swing is chosen
// - crystal start-up table for lowest select bit zero
// - crystal start-up table for lowest select bit one
// - stopping core clock halts register file, status and stack memory
// - io clock runs peripherals; some external interrupts sensed without a clock
// - two-wire slave address match works while io clock is stopped
// - flash clock follows core clock
// - async timer clock is an independent domain from a 32kHz crystal
// - converter clock is separate so core and io clocks may stop
// - sleep mode selection gates off clocks of unused modules
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
module cssu_clock_select_startup
    import cssu_pkg::*;
#(
    parameter int WD_SHORT = CSSU_WD_4K,
    parameter int WD_LONG  = CSSU_WD_64K
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // clock sources
    input  wire logic        source_clock,
    input  wire logic        watchdog_clock,
    input  wire logic        async_crystal_clock,
    // asynchronous wake events
    input  wire logic        async_wake_pin,
    // gate enables (registered) for the clock domains
    output logic             core_clock_en,
    output logic             io_clock_en,
    output logic             flash_clock_en,
    output logic             async_timer_clock_en,
    output logic             converter_clock_en,
    output logic             run_ready
);

    // ==========================================================
    // fuse and control state
    logic [3:0]  fuse_cksel_ff, nxt_fuse_cksel;
    logic [1:0]  fuse_sut_ff, nxt_fuse_sut;
    logic        fuse_swing_ff, nxt_fuse_swing;
    logic [2:0]  sleep_ff, nxt_sleep;
    logic        conv_en_ff, nxt_conv_en;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pslverr_ff, nxt_pslverr;
    logic [1:0]  src_sync_ff, wd_sync_ff, pin_sync_ff;

    cssu_src_t   src;
    cssu_range_t range;
    logic [16:0] osc_count;
    cssu_rdly_t  rst_delay;
    logic        reserved;

    // fuses default to the shipped setting after reset
    cssu_decode u_decode (
        .clock_source_select    (fuse_cksel_ff),
        .startup_time_select    (fuse_sut_ff),
        .amplifier_swing_option (fuse_swing_ff),
        .src                    (src),
        .range                  (range),
        .osc_count              (osc_count),
        .rst_delay              (rst_delay),
        .reserved               (reserved)
    );

    // ==========================================================
    // apb access, zero wait states
    logic wr_en;
    logic rd_en;
    logic wake_req;
    logic seq_busy;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    function automatic logic addr_ok(input logic [11:0] a);
        return (a == CSSU_FUSE_OFF) || (a == CSSU_CTRL_OFF) || (a == CSSU_STAT_OFF);
    endfunction

    always_comb begin
        nxt_fuse_cksel = fuse_cksel_ff;
        nxt_fuse_sut   = fuse_sut_ff;
        nxt_fuse_swing = fuse_swing_ff;
        nxt_sleep      = sleep_ff;
        nxt_conv_en    = conv_en_ff;
        nxt_prdata     = prdata_ff;
        nxt_pslverr    = 1'b0;
        wake_req       = 1'b0;
        if (psel & ~penable) begin
            nxt_pslverr = ~addr_ok(paddr);
            nxt_prdata  = 32'h0000_0000;
            if (!pwrite && paddr == CSSU_FUSE_OFF) begin
                nxt_prdata = {25'h0, fuse_swing_ff, fuse_sut_ff, fuse_cksel_ff};
            end else if (!pwrite && paddr == CSSU_CTRL_OFF) begin
                nxt_prdata = {28'h0, conv_en_ff, sleep_ff};
            end else if (!pwrite && paddr == CSSU_STAT_OFF) begin
                nxt_prdata = {23'h0, reserved, rst_delay, range, src, run_ready};
            end
        end
        // the pin wakes any sleep mode even with io clock stopped; a ctrl write below wins
        if (pin_sync_ff[1] && sleep_ff != 3'(CSSU_SLP_ACTIVE)) begin
            nxt_sleep = 3'(CSSU_SLP_ACTIVE);
        end
        // fuses feed the decoder directly; status and a running count follow a write at once
        if (wr_en && paddr == CSSU_FUSE_OFF) begin
            nxt_fuse_cksel = pwdata[CSSU_CKSEL_LSB +: 4];
            nxt_fuse_sut   = pwdata[CSSU_SUT_LSB +: 2];
            nxt_fuse_swing = pwdata[CSSU_SWING_BIT];
        end
        if (wr_en && paddr == CSSU_CTRL_OFF) begin
            nxt_sleep   = pwdata[CSSU_SLEEP_LSB +: 3];
            nxt_conv_en = pwdata[CSSU_CONV_BIT];
            wake_req    = pwdata[CSSU_WAKE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_cksel_ff <= CSSU_CKSEL_RST;
            fuse_sut_ff   <= CSSU_SUT_RST;
            fuse_swing_ff <= CSSU_SWING_RST;
            sleep_ff      <= 3'(CSSU_SLP_ACTIVE);
            conv_en_ff    <= 1'b0;
            prdata_ff     <= 32'h0000_0000;
            pslverr_ff    <= 1'b0;
        end else begin
            fuse_cksel_ff <= nxt_fuse_cksel;
            fuse_sut_ff   <= nxt_fuse_sut;
            fuse_swing_ff <= nxt_fuse_swing;
            sleep_ff      <= nxt_sleep;
            conv_en_ff    <= nxt_conv_en;
            prdata_ff     <= nxt_prdata;
            pslverr_ff    <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = pslverr_ff;

    // ==========================================================
    // synchronisers for foreign clocks and the wake pin
    logic       src_prev_ff, wd_prev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sync_ff <= 2'h0;
            wd_sync_ff  <= 2'h0;
            pin_sync_ff <= 2'h0;
            src_prev_ff <= 1'b0;
            wd_prev_ff  <= 1'b0;
        end else begin
            src_sync_ff <= {src_sync_ff[0], source_clock};
            wd_sync_ff  <= {wd_sync_ff[0], watchdog_clock};
            pin_sync_ff <= {pin_sync_ff[0], async_wake_pin};
            src_prev_ff <= src_sync_ff[1];
            wd_prev_ff  <= wd_sync_ff[1];
        end
    end

    logic src_tick;
    logic wd_tick;
    assign src_tick = src_sync_ff[1] & ~src_prev_ff;
    assign wd_tick  = wd_sync_ff[1] & ~wd_prev_ff;

    // ==========================================================
    // start-up sequencer
    typedef enum logic [1:0] {
        CSSU_ST_RESET, CSSU_ST_OSC, CSSU_ST_RUN, CSSU_ST_SLEEP
    } cssu_seq_t;

    cssu_seq_t   state_ff, nxt_state;
    logic [16:0] cnt_ff, nxt_cnt;
    logic [16:0] wd_limit;
    logic        deep_sleep;
    logic        run_ff, nxt_run;

    assign deep_sleep = (sleep_ff == 3'(CSSU_SLP_PDOWN)) || (sleep_ff == 3'(CSSU_SLP_PSAVE));
    assign seq_busy   = (state_ff != CSSU_ST_RUN);

    always_comb begin
        unique case (rst_delay)
            CSSU_RD_4K:  wd_limit = 17'(WD_SHORT);
            CSSU_RD_64K: wd_limit = 17'(WD_LONG);
            default:     wd_limit = 17'h0_0000;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_run   = 1'b0;
        unique case (state_ff)
            // reset delay runs on watchdog cycles, not the system clock
            CSSU_ST_RESET: begin
                if (cnt_ff >= wd_limit) begin
                    nxt_state = CSSU_ST_OSC;
                    nxt_cnt   = 17'h0_0000;
                end else if (wd_tick) begin
                    nxt_cnt = cnt_ff + 17'h0_0001;
                end
            end
            // oscillator count in cycles of the selected source
            CSSU_ST_OSC: begin
                if (cnt_ff >= osc_count) begin
                    nxt_state = CSSU_ST_RUN;
                    nxt_cnt   = 17'h0_0000;
                    nxt_run   = 1'b1;
                end else if (src_tick) begin
                    nxt_cnt = cnt_ff + 17'h0_0001;
                end
            end
            CSSU_ST_RUN: begin
                nxt_run = 1'b1;
                if (deep_sleep) begin
                    nxt_state = CSSU_ST_SLEEP;
                    nxt_run   = 1'b0;
                end
            end
            // wake from deep sleep skips the reset delay
            CSSU_ST_SLEEP: begin
                if (wake_req || pin_sync_ff[1]) begin
                    nxt_state = CSSU_ST_OSC;
                    nxt_cnt   = 17'h0_0000;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= CSSU_ST_RESET;
            cnt_ff   <= 17'h0_0000;
            run_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            run_ff   <= nxt_run;
        end
    end

    // ==========================================================
    // clock domain gating by sleep mode
    logic core_en_ff, io_en_ff, asy_en_ff, conv_ff;
    logic nxt_core_en, nxt_io_en, nxt_asy_en, nxt_conv;

    always_comb begin
        nxt_core_en = nxt_run && (nxt_sleep == 3'(CSSU_SLP_ACTIVE));
        nxt_io_en   = nxt_run && (nxt_sleep == 3'(CSSU_SLP_ACTIVE) || nxt_sleep == 3'(CSSU_SLP_IDLE));
        // async timer survives every sleep except power-down
        nxt_asy_en  = (nxt_sleep != 3'(CSSU_SLP_PDOWN));
        nxt_conv    = nxt_run && nxt_conv_en && !deep_sleep;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_en_ff <= 1'b0;
            io_en_ff   <= 1'b0;
            asy_en_ff  <= 1'b0;
            conv_ff    <= 1'b0;
        end else begin
            core_en_ff <= nxt_core_en;
            io_en_ff   <= nxt_io_en;
            asy_en_ff  <= nxt_asy_en;
            conv_ff    <= nxt_conv;
        end
    end

    // the real gate for the async domain sits on its own crystal clock
    logic async_gated;
    cssu_gate u_async_gate (
        .clk_in  (async_crystal_clock),
        .rst_n   (presetn),
        .enable  (asy_en_ff),
        .clk_out (async_gated)
    );

    assign core_clock_en        = core_en_ff;
    assign flash_clock_en       = core_en_ff;
    assign io_clock_en          = io_en_ff;
    assign async_timer_clock_en = asy_en_ff;
    assign converter_clock_en   = conv_ff;
    assign run_ready            = run_ff;

    // ==========================================================
    // checks
    a_core_gated_startup: assert property (@(posedge pclk) disable iff (!presetn)
        seq_busy |-> !core_en_ff)
        else $error("core clock enabled before start-up finished");
    a_flash_follows_core: assert property (@(posedge pclk) disable iff (!presetn)
        flash_clock_en == core_clock_en)
        else $error("flash clock differs from core clock");
    a_wake_to_osc: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == CSSU_ST_SLEEP && wake_req) |=> (state_ff == CSSU_ST_OSC && cnt_ff == 17'h0_0000))
        else $error("wake did not start oscillator count");
    a_reset_delay_end: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == CSSU_ST_RESET && cnt_ff < wd_limit) |=> state_ff == CSSU_ST_RESET)
        else $error("reset delay left early");
    a_osc_count_end: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == CSSU_ST_OSC && cnt_ff < osc_count) |=> state_ff != CSSU_ST_RUN)
        else $error("oscillator count cut short");
    a_deep_sleep_core: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == CSSU_ST_SLEEP) |-> !core_en_ff && !io_en_ff)
        else $error("clocks running in deep sleep");
    a_core_stops_halt: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(run_ff) |-> ##1 !core_en_ff)
        else $error("core clock ran after halt");
    a_io_with_core: assert property (@(posedge pclk) disable iff (!presetn)
        core_en_ff |-> io_en_ff)
        else $error("io clock off while core clock on");

endmodule // cssu_clock_select_startup

// file: cssu_clock_select_startup_test.sv
// self-checking bench for the clock select and start-up block
`timescale 1ns/1ns
module cssu_clock_select_startup_test
    import cssu_pkg::*;
;
    // ==========================================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        src_clk, wd_clk, asy_clk, wake, err;
    logic        core_en, io_en, fl_en, asy_en, cnv_en, run_ready;
    int          failures, num_checks;

    // small reset delay keeps the run short: 16 watchdog ticks
    cssu_clock_select_startup #(.WD_SHORT(4), .WD_LONG(16)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_clock(src_clk),
        .watchdog_clock(wd_clk), .async_crystal_clock(asy_clk),
        .async_wake_pin(wake), .core_clock_en(core_en), .io_clock_en(io_en),
        .flash_clock_en(fl_en), .async_timer_clock_en(asy_en),
        .converter_clock_en(cnv_en), .run_ready(run_ready));
    cssu_osc_model i_osc (.source_clock(src_clk), .watchdog_clock(wd_clk),
        .async_crystal_clock(asy_clk));

    // ==========================================================
    // clock, time-zero values, watchdog
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; wake = 1'b0;
        failures = 0; num_checks = 0;
    end
    always #25 pclk = ~pclk;
    initial begin
        #2000000;
        failures++;
        print_verdict();
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench watchdog ends a transfer that never gets pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // counts cycles until an enable or flag rises, bounded
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1 && n < 400) begin @(posedge pclk); n++; end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        int n;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({core_en, io_en, fl_en, run_ready}, 4'h0, "enables in reset");
        presetn <= 1'b1;
        apb(1'b0, CSSU_FUSE_OFF, 32'h0);
        chk(rd[6:0], 7'h61, "factory fuses");
        apb(1'b0, CSSU_STAT_OFF, 32'h0);
        chk(rd[8:0], {1'b0, 2'(CSSU_RD_64K), 2'(CSSU_RNG_WIDE), 3'(CSSU_SRC_INTRC), 1'b0}, "default stat");
        wait_hi(run_ready, n);
        // 16 watchdog ticks of about 8 cycles come before the 6 source ticks
        chk(n >= 120 && n <= 200, 1, "reset delay length");
        @(posedge pclk);
        @(negedge pclk);
        chk({core_en, io_en, fl_en}, 3'h7, "enables after start-up");
    endtask
    task automatic t_decode();
        logic [2:0] s;
        for (int c = 0; c < 16; c++) begin
            s = c >= 10 ? 3'd0 : c == 9 ? 3'd1 : c >= 5 ? 3'd2 : c >= 1 ? 3'd3 : 3'd4;
            apb(1'b1, CSSU_FUSE_OFF, 32'h50 | c);
            apb(1'b0, CSSU_STAT_OFF, 32'h0);
            chk(rd[3:1], s, "source code");
            if (c >= 10) chk(rd[5:4], c[3:1] - 3'd5, "crystal range");
        end
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, CSSU_FUSE_OFF, 32'h4A | (k[2] << 0) | (k[1:0] << 4));
            apb(1'b0, CSSU_STAT_OFF, 32'h0);
            chk(rd[7:6], (k[2] ? 8'h92 : 8'h49) >> (2 * k[1:0]) & 2'h3, "crystal delay");
        end
        apb(1'b1, CSSU_FUSE_OFF, 32'h0E);
        apb(1'b0, CSSU_STAT_OFF, 32'h0);
        chk(rd[5:4], CSSU_RNG_WIDE, "full swing range");
        apb(1'b1, CSSU_FUSE_OFF, 32'h71);
        apb(1'b0, CSSU_STAT_OFF, 32'h0);
        chk(rd[8], 1'b1, "reserved start-up code");
        apb(1'b1, 12'h0FC, 32'h0);
        chk(err, 1'b1, "unmapped address");
        apb(1'b1, CSSU_FUSE_OFF, 32'h61);
    endtask
    // enter a sleep mode, check gating, wake by pin or by the ctrl wake strobe, time the return
    task automatic t_sleep(input logic [2:0] m, input logic [4:0] e, input int lo, input bit by_reg);
        int n;
        apb(1'b1, CSSU_CTRL_OFF, {28'h0, 1'b1, m});
        repeat (3) @(posedge pclk);
        chk({core_en, fl_en, io_en, asy_en, cnv_en}, e, "sleep gating");
        if (by_reg) begin
            apb(1'b1, CSSU_CTRL_OFF, 32'h18);
        end else begin
            wake <= 1'b1;
        end
        wait_hi(core_en, n);
        // deep sleep returns after the 6-cycle source count, no reset delay
        chk(n >= lo && n <= 80, 1, "wake time");
        wake <= 1'b0;
        apb(1'b1, CSSU_CTRL_OFF, 32'h8);
        chk({fl_en, core_en}, 2'b11, "flash follows core");
    endtask

    // ==========================================================
    // closing and main sequence
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_decode();
        t_sleep(3'd1, 5'b00111, 0, 1'b0);
        t_sleep(3'd2, 5'b00011, 0, 1'b0);
        t_sleep(3'd3, 5'b00000, 20, 1'b0);
        t_sleep(3'd4, 5'b00010, 20, 1'b1);
        apb(1'b1, CSSU_FUSE_OFF, 32'h00);
        t_reset();
        print_verdict();
    end
endmodule // cssu_clock_select_startup_test

// file: cssu_decode.sv
// fuse decoder: clock source, range and start-up counts
`timescale 1ns/1ns
module cssu_decode
    import cssu_pkg::*;
(
    // fuse inputs
    input  wire logic [3:0]  clock_source_select,
    input  wire logic [1:0]  startup_time_select,
    input  wire logic        amplifier_swing_option,
    // decoded outputs
    output cssu_src_t        src,
    output cssu_range_t      range,
    output logic [16:0]      osc_count,
    output cssu_rdly_t       rst_delay,
    output logic             reserved
);

    logic [2:0] crystal_range_select;
    logic       crystal_startup_group;

    assign crystal_range_select  = clock_source_select[3:1];
    assign crystal_startup_group = clock_source_select[0];

    // decode of source class; zero bits mean programmed
    always_comb begin
        src       = CSSU_SRC_EXTCLK;
        range     = CSSU_RNG_WIDE;
        osc_count = 17'(CSSU_CK_6);
        rst_delay = CSSU_RD_NONE;
        reserved  = 1'b0;
        if (clock_source_select >= 4'hA) begin
            src = CSSU_SRC_XTAL;
            // full swing amplifier spans every range code
            if (!amplifier_swing_option) begin
                range = CSSU_RNG_WIDE;
            end else if (crystal_range_select == 3'h5) begin
                range = CSSU_RNG_LOW;
            end else if (crystal_range_select == 3'h6) begin
                range = CSSU_RNG_MID;
            end else begin
                range = CSSU_RNG_HIGH;
            end
            unique case ({crystal_startup_group, startup_time_select})
                3'h0: begin osc_count = 17'(CSSU_CK_258); rst_delay = CSSU_RD_4K;  end
                3'h1: begin osc_count = 17'(CSSU_CK_258); rst_delay = CSSU_RD_64K; end
                3'h2: begin osc_count = 17'(CSSU_CK_1K);  rst_delay = CSSU_RD_NONE; end
                3'h3: begin osc_count = 17'(CSSU_CK_1K);  rst_delay = CSSU_RD_4K;  end
                3'h4: begin osc_count = 17'(CSSU_CK_1K);  rst_delay = CSSU_RD_64K; end
                3'h5: begin osc_count = 17'(CSSU_CK_16K); rst_delay = CSSU_RD_NONE; end
                3'h6: begin osc_count = 17'(CSSU_CK_16K); rst_delay = CSSU_RD_4K;  end
                3'h7: begin osc_count = 17'(CSSU_CK_16K); rst_delay = CSSU_RD_64K; end
            endcase
        end else if (clock_source_select == 4'h9) begin
            src = CSSU_SRC_LFXTAL;
            unique case (startup_time_select)
                2'h0: begin osc_count = 17'(CSSU_CK_1K);  rst_delay = CSSU_RD_4K;  end
                2'h1: begin osc_count = 17'(CSSU_CK_1K);  rst_delay = CSSU_RD_64K; end
                2'h2: begin osc_count = 17'(CSSU_CK_32K); rst_delay = CSSU_RD_64K; end
                2'h3: reserved = 1'b1;
            endcase
        end else if (clock_source_select >= 4'h5) begin
            src = CSSU_SRC_EXTRC;
            unique case (startup_time_select)
                2'h0: begin osc_count = 17'(CSSU_CK_18); rst_delay = CSSU_RD_NONE; end
                2'h1: begin osc_count = 17'(CSSU_CK_18); rst_delay = CSSU_RD_4K;  end
                2'h2: begin osc_count = 17'(CSSU_CK_18); rst_delay = CSSU_RD_64K; end
                2'h3: begin osc_count = 17'(CSSU_CK_6);  rst_delay = CSSU_RD_4K;  end
            endcase
        end else if (clock_source_select >= 4'h1) begin
            src = CSSU_SRC_INTRC;
            unique case (startup_time_select)
                2'h0: rst_delay = CSSU_RD_NONE;
                2'h1: rst_delay = CSSU_RD_4K;
                2'h2: rst_delay = CSSU_RD_64K;
                2'h3: reserved  = 1'b1;
            endcase
        end else begin
            // external clock: only the first start-up row is known, others reuse its count
            src = CSSU_SRC_EXTCLK;
        end
    end

endmodule // cssu_decode

// file: cssu_gate.sv
// glitch-free clock gate: latch-free enable retimed on the falling edge
`timescale 1ns/1ns
module cssu_gate (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n,
    // enable and gated clock
    input  wire logic enable,
    output logic      clk_out
);

    logic en_ff;

    // enable changes only while clk_in is low, so no runt pulses
    always_ff @(negedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= 1'b0;
        end else begin
            en_ff <= enable;
        end
    end

    assign clk_out = clk_in & en_ff;

endmodule // cssu_gate

// file: cssu_osc_model.sv
// oscillator sources: selected source, watchdog and async crystal with a 1034 ns period
`timescale 1ns/1ns
module cssu_osc_model #(
    parameter int SRC_HALF = 103,
    parameter int WD_HALF  = 203,
    parameter int ASY_HALF = 517
) (
    // oscillator outputs
    output logic source_clock,
    output logic watchdog_clock,
    output logic async_crystal_clock
);
    // ==========================================================
    // free-running sources, half periods off pclk so phases drift
    initial begin
        source_clock        = 1'b0;
        watchdog_clock      = 1'b0;
        async_crystal_clock = 1'b0;
    end
    // a ceramic resonator well below top speed, so short counts are legal
    always #(SRC_HALF) source_clock = ~source_clock;
    always #(WD_HALF) watchdog_clock = ~watchdog_clock;
    // the async crystal clock, 1034 ns period here, runs on through every sleep mode
    always #(ASY_HALF) async_crystal_clock = ~async_crystal_clock;
endmodule // cssu_osc_model

// file: cssu_pkg.sv
// package of constants and types for the clock source select and start-up block
package cssu_pkg;

    // ==========================================================
    // register map (apb byte addresses)
    localparam logic [11:0] CSSU_FUSE_OFF   = 12'h000;
    localparam logic [11:0] CSSU_CTRL_OFF   = 12'h004;
    localparam logic [11:0] CSSU_STAT_OFF   = 12'h008;

    // ==========================================================
    // fuse word field positions
    localparam int CSSU_CKSEL_LSB = 0;
    localparam int CSSU_SUT_LSB   = 4;
    localparam int CSSU_SWING_BIT = 6;

    // factory fuse values, one means unprogrammed
    localparam logic [3:0] CSSU_CKSEL_RST = 4'h1;
    localparam logic [1:0] CSSU_SUT_RST   = 2'h2;
    localparam logic       CSSU_SWING_RST = 1'b1;

    // ==========================================================
    // ctrl register field positions
    localparam int CSSU_SLEEP_LSB = 0;
    localparam int CSSU_CONV_BIT  = 3;
    localparam int CSSU_WAKE_BIT  = 4;

    // ==========================================================
    // start-up counts in source cycles
    localparam int CSSU_CK_6    = 6;
    localparam int CSSU_CK_18   = 18;
    localparam int CSSU_CK_258  = 258;
    localparam int CSSU_CK_1K   = 1024;
    localparam int CSSU_CK_16K  = 16384;
    localparam int CSSU_CK_32K  = 32768;
    // reset delays in watchdog oscillator cycles
    localparam int CSSU_WD_4K   = 4096;
    localparam int CSSU_WD_64K  = 65536;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CSSU_SRC_XTAL, CSSU_SRC_LFXTAL, CSSU_SRC_EXTRC, CSSU_SRC_INTRC, CSSU_SRC_EXTCLK
    } cssu_src_t;

    typedef enum logic [1:0] {
        CSSU_RNG_LOW, CSSU_RNG_MID, CSSU_RNG_HIGH, CSSU_RNG_WIDE
    } cssu_range_t;

    typedef enum logic [1:0] {
        CSSU_RD_NONE, CSSU_RD_4K, CSSU_RD_64K
    } cssu_rdly_t;

    typedef enum logic [2:0] {
        CSSU_SLP_ACTIVE, CSSU_SLP_IDLE, CSSU_SLP_CONV, CSSU_SLP_PDOWN, CSSU_SLP_PSAVE
    } cssu_sleep_t;

endpackage
